// ===== src/smd_top.sv
// module: swap steering delay, dither control and sample lsb control registers
// ********************************************
// ********************************************
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module smd_top
  import smd_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  // register port
  input  wire logic [11:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  // factory fuse word for dither defaults
  input  wire logic [2:0]  I_FUSE_DITHER,
  // swap path
  input  wire logic        I_SWAP_BUSY,
  input  wire logic        I_STEER_SEL,
  output logic             O_STEER_SEL,
  // dither and marker controls
  output logic             O_DITHER_ON,
  output logic             O_DITHER_SIZE_SEL,
  output logic             O_ROUND_ERR_SEL,
  output logic             O_LSB_MARKER_ON
);

  // ********************************************
  // registers
  // ********************************************
  logic [DELAY_W-1:0]  swap_steer_delay;
  logic [DITHER_W-1:0] dither_ctrl;
  logic                lsb_marker_on;
  logic                fuse_load;
  logic [2:0]          fuse_s1;
  logic [2:0]          fuse_s2;
  logic                busy_s1;
  logic                busy_s2;
  logic                sel_s1;
  logic                sel_s2;
  smd_cfg_if           cfg ();

  // ********************************************
  // decode
  // ********************************************
  wire hit_delay  = I_ADDR == SWAP_STEER_DELAY_ADDR;
  wire hit_dither = I_ADDR == DITHER_CONTROL_ADDR;
  wire hit_lsb    = I_ADDR == SAMPLE_LSB_CONTROL_ADDR;
  // reserved bits are dropped on write; writers must send zero anyway
  wire [7:0] rd_mux = hit_delay  ? {3'h0, swap_steer_delay} :
                      hit_dither ? {5'h00, dither_ctrl} :
                      hit_lsb    ? {7'h00, lsb_marker_on} : READ_ZERO;

  // fuse pins are static but asynchronous, so resample before use
  always_ff @(posedge I_CLK) begin
    fuse_s1 <= I_FUSE_DITHER;
    fuse_s2 <= fuse_s1;
    busy_s1 <= I_SWAP_BUSY;
    busy_s2 <= busy_s1;
    sel_s1  <= I_STEER_SEL;
    sel_s2  <= sel_s1;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      swap_steer_delay <= SWAP_STEER_DELAY_RST;
      lsb_marker_on    <= SAMPLE_LSB_RST[0];
      fuse_load        <= 1'b1;
      dither_ctrl      <= '0;
    end else begin
      fuse_load <= 1'b0;
      if (I_WR && hit_delay) begin
        swap_steer_delay <= I_WDATA[DELAY_W-1:0];
      end
      if (I_WR && hit_lsb) begin
        lsb_marker_on <= I_WDATA[LSB_MARKER_BIT];
      end
      // defaults captured one cycle after release; a write still wins later
      if (fuse_load) begin
        dither_ctrl <= fuse_s2;
      end else if (I_WR && hit_dither) begin
        dither_ctrl <= I_WDATA[DITHER_W-1:0];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_RDATA           <= '0;
      O_DITHER_ON       <= 1'b0;
      O_DITHER_SIZE_SEL <= 1'b0;
      O_ROUND_ERR_SEL   <= 1'b0;
      O_LSB_MARKER_ON   <= 1'b0;
      O_STEER_SEL       <= 1'b0;
    end else begin
      O_RDATA           <= I_RD ? rd_mux : READ_ZERO;
      O_DITHER_ON       <= dither_ctrl[DITHER_ON_BIT];
      O_DITHER_SIZE_SEL <= dither_ctrl[DITHER_SIZE_BIT];
      O_ROUND_ERR_SEL   <= dither_ctrl[ROUND_ERR_BIT];
      O_LSB_MARKER_ON   <= lsb_marker_on;
      O_STEER_SEL       <= cfg.sel_out;
    end
  end

  // ********************************************
  // select delay line
  // ********************************************
  assign cfg.steer_delay = swap_steer_delay;
  assign cfg.swap_busy   = busy_s2;
  assign cfg.sel_in      = sel_s2;

  smd_sel_delay u_delay (
    .I_CLK  (I_CLK),
    .I_RSTN (I_RSTN),
    .cfg    (cfg.path)
  );

  // ********************************************
  // checks
  // ********************************************
  AST_DELAY_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_WR && hit_delay |=> swap_steer_delay == $past(I_WDATA[4:0]))
    else $error("delay write lost");
  AST_RESERVED_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_RD && hit_dither |=> O_RDATA[7:3] == 5'h00) else $error("reserved bits not zero");
  AST_DITHER_ON: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_DITHER_ON == $past(dither_ctrl[0])) else $error("dither enable mismatch");
  AST_DITHER_SIZE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_WR && hit_dither && !fuse_load |=> ##1 O_DITHER_SIZE_SEL == $past(I_WDATA[1], 2))
    else $error("amplitude select mismatch");
  AST_ROUND_ERR: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_WR && hit_dither && !fuse_load |=> ##1 O_ROUND_ERR_SEL == $past(I_WDATA[2], 2))
    else $error("rounding select mismatch");
  AST_FUSE_LOAD: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    fuse_load |=> dither_ctrl == $past(fuse_s2)) else $error("fuse defaults not loaded");
  AST_LSB_RESET: assert property (@(posedge I_CLK)
    !I_RSTN |=> lsb_marker_on == 1'b0) else $error("lsb control not reset");
  AST_LSB_MARKER: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_WR && hit_lsb |=> ##1 O_LSB_MARKER_ON == $past(I_WDATA[0], 2))
    else $error("marker enable mismatch");
  AST_STEER_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !busy_s2 |=> O_STEER_SEL == $past(sel_s2)) else $error("steer delayed while idle");

endmodule : smd_top

// ===== src/smd_pkg.sv
// package: register map, field layout and reset values of the swap/dither control bank
package smd_pkg;

  // ********************************************
  // register offsets
  // ********************************************
  localparam logic [11:0] SWAP_STEER_DELAY_ADDR   = 12'h009B;
  localparam logic [11:0] DITHER_CONTROL_ADDR     = 12'h009D;
  localparam logic [11:0] SAMPLE_LSB_CONTROL_ADDR = 12'h0160;

  // ********************************************
  // field layout
  // ********************************************
  localparam int DELAY_W        = 5;
  localparam int DITHER_ON_BIT  = 0;
  localparam int DITHER_SIZE_BIT = 1;
  localparam int ROUND_ERR_BIT  = 2;
  localparam int DITHER_W       = 3;
  localparam int LSB_MARKER_BIT = 0;

  // ********************************************
  // reset values and fixed constants
  // ********************************************
  localparam logic [4:0] SWAP_STEER_DELAY_RST = 5'h07;
  localparam logic [7:0] SAMPLE_LSB_RST       = 8'h00;
  localparam logic [7:0] READ_ZERO            = 8'h00;
  localparam logic [4:0] DELAY_MAX            = 5'h1F;

endpackage : smd_pkg

// ===== src/smd_cfg_if.sv
// interface: configuration carried from the register bank to the data-path helper
`timescale 1ns/1ps
interface smd_cfg_if;
  import smd_pkg::*;
  logic [DELAY_W-1:0] steer_delay;
  logic               swap_busy;
  logic               sel_in;
  logic               sel_out;
  modport bank (output steer_delay, output swap_busy, output sel_in, input sel_out);
  modport path (input steer_delay, input swap_busy, input sel_in, output sel_out);
endinterface : smd_cfg_if

// ===== src/smd_sel_delay.sv
// module: programmable delay line on the core-steering select signal
`timescale 1ns/1ps
module smd_sel_delay
  import smd_pkg::*;
(
  // clock and reset
  input  wire logic I_CLK,
  input  wire logic I_RSTN,
  // configuration
  smd_cfg_if.path   cfg
);

  // ********************************************
  // delay shift register
  // ********************************************
  localparam int DEPTH = 32;
  logic [DEPTH-1:0] tap;
  logic             delayed;

  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      tap <= '0;
    end else begin
      tap <= {tap[DEPTH-2:0], cfg.sel_in};
    end
  end

  // tap zero of the chain lags the live select by one cycle, so a delay of 0 bypasses the chain and adds nothing
  assign delayed     = (cfg.steer_delay == '0) ? cfg.sel_in : tap[cfg.steer_delay - 5'h01];
  // outside a swap the raw select passes straight through
  assign cfg.sel_out = cfg.swap_busy ? delayed : cfg.sel_in;

  AST_NO_DELAY_IDLE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    !cfg.swap_busy |-> cfg.sel_out == cfg.sel_in) else $error("delay leaked outside swap");

endmodule : smd_sel_delay

// ===== bench/swap_mux_dither_ctrl_bench.sv
// bench: self-checking test of the swap/dither control bank
`timescale 1ns/1ps
module swap_mux_dither_ctrl_bench
  import smd_pkg::*;
;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, swap = 0, sel = 0;
  logic [11:0] addr = 12'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  fuse = 3'h5;
  logic [7:0]  rdata;
  logic        o_sel, o_on, o_size, o_err, o_mark;
  int          fail_count = 0, num_checks = 0;

  smd_top u_smd_top (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_FUSE_DITHER(fuse), .I_SWAP_BUSY(swap), .I_STEER_SEL(sel),
    .O_STEER_SEL(o_sel), .O_DITHER_ON(o_on), .O_DITHER_SIZE_SEL(o_size),
    .O_ROUND_ERR_SEL(o_err), .O_LSB_MARKER_ON(o_mark));

  always #5 clk = ~clk;

  // ********************************************
  // shared tasks
  // ********************************************
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // returns once the control outputs of the write have landed
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0;
    @(posedge clk); #1;
  endtask : wr_reg

  task rd_chk(input string n, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk); rd <= 1'b1; addr <= a;
    @(posedge clk); rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask : rd_chk

  // ********************************************
  // scenarios
  // ********************************************
  task t_reset;
    rd_chk("delay", SWAP_STEER_DELAY_ADDR, 8'h07);
    rd_chk("lsb", SAMPLE_LSB_CONTROL_ADDR, 8'h00);
    rd_chk("dither", DITHER_CONTROL_ADDR, 8'h05);
    chk("dither_pins", 8'h05, {5'h00, o_err, o_size, o_on});
    $display("test reset done");
  endtask : t_reset

  task t_delay;
    wr_reg(SWAP_STEER_DELAY_ADDR, 8'h1F);
    rd_chk("delay", SWAP_STEER_DELAY_ADDR, 8'h1F);
    wr_reg(SWAP_STEER_DELAY_ADDR, 8'h00);
    rd_chk("delay", SWAP_STEER_DELAY_ADDR, 8'h00);
    wr_reg(12'h009C, 8'hFF);
    rd_chk("unmapped", 12'h009C, 8'h00);
    rd_chk("delay", SWAP_STEER_DELAY_ADDR, 8'h00);
    $display("test delay done");
  endtask : t_delay

  task t_dither;
    for (int i = 0; i < 8; i++) begin
      wr_reg(DITHER_CONTROL_ADDR, 8'(i));
      chk("dither_pins", 8'(i), {5'h00, o_err, o_size, o_on});
      rd_chk("dither", DITHER_CONTROL_ADDR, 8'(i));
    end
    $display("test dither done");
  endtask : t_dither

  task t_lsb;
    wr_reg(SAMPLE_LSB_CONTROL_ADDR, 8'h01);
    chk("marker", 8'h01, {7'h00, o_mark});
    wr_reg(SAMPLE_LSB_CONTROL_ADDR, 8'h00);
    chk("marker", 8'h00, {7'h00, o_mark});
    $display("test lsb done");
  endtask : t_lsb

  // counts edges from the drive of a rising select to its arrival
  task t_steer(input logic busy, input logic [4:0] d);
    logic [7:0] n;
    wr_reg(SWAP_STEER_DELAY_ADDR, {3'h0, d});
    @(posedge clk);
    swap <= busy;
    sel  <= 1'b0;
    repeat (45) @(posedge clk);
    sel <= 1'b1;
    n = 8'h00;
    while (o_sel !== 1'b1 && n < 8'h3C) begin
      @(posedge clk); #1;
      n++;
    end
    chk("steer_edges", 8'h03 + (busy ? {3'h0, d} : 8'h00), n);
    @(posedge clk); sel <= 1'b0; swap <= 1'b0;
    $display("test steer done");
  endtask : t_steer

  // ********************************************
  // run control
  // ********************************************
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_delay;
    t_dither;
    t_lsb;
    t_steer(1'b0, 5'h05);
    t_steer(1'b1, 5'h05);
    t_steer(1'b1, 5'h00);
    t_steer(1'b1, 5'h1F);
    results;
  end

  // tests take well under a thousand cycles
  initial begin
    #50000;
    fail_count++;
    results;
  end
endmodule : swap_mux_dither_ctrl_bench
